// File: rtl/fbdi_ctrl.sv
// fbdi_ctrl: fast page mode frame buffer controller with apb register access
//
// The placing of the registers and the APB register port were decided locally.
module fbdi_ctrl import fbdi_pkg::*; #(
	parameter int IDLE_CLOSE = IDLE_CLOSE_MCLK
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// dram pins
	output fbdi_pins_t dram,
	output logic [63:0] dq_out,
	input wire logic [63:0] dq_in
);
	if (MCLK_DIV < 1 || IDLE_CLOSE < 1 || IDLE_CLOSE > 255) begin : g_chk
		$error("fbdi_ctrl: unsupported divider or idle count");
	end

	fbdi_cfg_t cfg_reg;
	fbdi_tim_t tim_reg;
	fbdi_state_t state_reg, state_next;
	fbdi_pins_t pins_reg, pins_next, cas_pins;
	logic [31:0] lin_reg, haddr_reg, prdata_reg, rd_mux;
	logic [63:0] wdata_reg, rdata_reg, dq_s1, dq_s2;
	logic [7:0] seg_reg, be_reg, idle_reg;
	logic [10:0] tag_reg;
	logic [2:0] div_reg;
	logic pready_reg, pslverr_reg, req_reg, wr_op_reg, done_reg, miss_reg, open_reg;
	logic mclk_en, ph_load, ph_zero, ras_load, ras_zero, take, fin, open_next;
	logic [3:0] ph_val;
	logic [10:0] tag_next;

	// memory clock enable: one pclk pulse per memory cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= mclk_en ? 3'h0 : div_reg + 3'h1;
		end
	end
	assign mclk_en = (div_reg == 3'(MCLK_DIV - 1));

	// window decode and address split
	fbdi_geom_t geom;
	logic [4:0] cap_l2;
	logic [31:0] cap, lin_off, leg_off, fb_off, word;
	logic lin_hit, leg_hit, win_hit, per_cas, bank;
	logic [9:0] col_a, row_a;
	logic [7:0] lanes, be_eff, cas_mask, we_mask;
	assign geom = fbdi_geom(cfg_reg.dtype);
	assign cap_l2 = fbdi_cap_l2(geom, cfg_reg.bus64, cfg_reg.two_banks);
	assign cap = 32'h1 << cap_l2;
	assign lin_off = haddr_reg - lin_reg;
	assign leg_off = {8'h00, seg_reg, 16'h0000} + (haddr_reg - LEG_LO);
	assign lin_hit = cfg_reg.lin_en && lin_reg >= LIN_MIN && haddr_reg >= lin_reg
		&& lin_off < cap && (!cfg_reg.isa || haddr_reg < ISA_TOP);
	assign leg_hit = cfg_reg.leg_en && haddr_reg >= LEG_LO && haddr_reg <= LEG_HI
		&& leg_off < cap;
	assign win_hit = lin_hit || leg_hit;
	assign fb_off = lin_hit ? lin_off : leg_off;
	assign word = cfg_reg.bus64 ? fb_off >> 3 : fb_off >> 2;
	assign col_a = 10'(word & ~(32'hffffffff << geom.col));
	assign row_a = 10'((word >> geom.col) & ~(32'hffffffff << geom.row));
	assign bank = geom.two_ras & cfg_reg.two_banks & word[5'(geom.col + geom.row)];
	assign tag_next = {bank, row_a};

	// strobe lanes: per-byte select on write or column lines, swappable
	assign lanes = cfg_reg.bus64 ? LANES_64 : LANES_32;
	assign be_eff = wr_op_reg ? (be_reg & lanes) : lanes;
	assign per_cas = geom.wide_cas ^ cfg_reg.swap;
	assign cas_mask = per_cas ? be_eff : lanes;
	assign we_mask = !wr_op_reg ? 8'h00 : (per_cas ? lanes : be_eff);
	assign cas_pins = '{col_a, pins_reg.ras_n, ~cas_mask, ~we_mask, wr_op_reg};

	// phase timer and row width timer
	fbdi_phase_cnt #(.W(4)) u_phase (
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_load),
		.val(ph_val),
		.dec(mclk_en),
		.zero(ph_zero)
	);
	fbdi_phase_cnt #(.W(4)) u_ras (
		.pclk(pclk),
		.presetn(presetn),
		.load(ras_load),
		.val(tim_reg.ras),
		.dec(mclk_en),
		.zero(ras_zero)
	);

	// cycle sequencer: precharge, activate, column, page hold and close
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		ph_load = 1'b0;
		ph_val = 4'h0;
		ras_load = 1'b0;
		take = 1'b0;
		fin = 1'b0;
		open_next = open_reg;
		if (mclk_en) begin
			case (state_reg)
				S_IDLE: begin
					if (req_reg && !win_hit) begin
						take = 1'b1;
					end else if (req_reg && open_reg && tag_reg == tag_next) begin
						state_next = S_CAS;
						pins_next = cas_pins;
						ph_load = 1'b1;
						ph_val = tim_reg.cas;
						take = 1'b1;
					end else if (open_reg && (req_reg || idle_reg == 8'h00)) begin
						state_next = S_CLOSE;
					end else if (req_reg) begin
						state_next = S_PRE;
						ph_load = 1'b1;
						ph_val = tim_reg.rp;
					end
				end
				S_CLOSE: begin
					if (ras_zero) begin
						pins_next.ras_n = 2'h3;
						state_next = S_PRE;
						ph_load = 1'b1;
						ph_val = tim_reg.rp;
						open_next = 1'b0;
					end
				end
				S_PRE: begin
					if (ph_zero && req_reg && win_hit) begin
						pins_next.addr = row_a;
						pins_next.ras_n = bank ? 2'h1 : 2'h2;
						state_next = S_RCD;
						ph_load = 1'b1;
						ph_val = tim_reg.rcd;
						ras_load = 1'b1;
						open_next = 1'b1;
					end else if (ph_zero) begin
						state_next = S_IDLE;
					end
				end
				S_RCD: begin
					if (ph_zero) begin
						pins_next = cas_pins;
						state_next = S_CAS;
						ph_load = 1'b1;
						ph_val = tim_reg.cas;
						take = 1'b1;
					end
				end
				S_CAS: begin
					if (ph_zero) begin
						pins_next = '{pins_reg.addr, pins_reg.ras_n, 8'hff, 8'hff, 1'b0};
						state_next = S_IDLE;
						fin = 1'b1;
					end
				end
				default: begin
					state_next = S_IDLE;
				end
			endcase
		end
	end

	// sequencer state, pins, open row and idle countdown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= S_IDLE;
			pins_reg <= PINS_IDLE;
			open_reg <= 1'b0;
			tag_reg <= 11'h000;
			idle_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			open_reg <= open_next;
			if (ras_load) begin
				tag_reg <= tag_next;
			end
			if (fin) begin
				idle_reg <= 8'(IDLE_CLOSE);
			end else if (mclk_en && state_reg == S_IDLE && idle_reg != 8'h00) begin
				idle_reg <= idle_reg - 8'h01;
			end
		end
	end

	// read data pins pass two flops; sampled as the column strobe ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_s1 <= 64'h0;
			dq_s2 <= 64'h0;
			rdata_reg <= 64'h0;
		end else begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
			if (fin && !wr_op_reg) begin
				rdata_reg <= dq_s2;
			end
		end
	end

	// apb decode: one access cycle, refusal decided at setup
	logic setup, acc_wr, busy, map_hit, data_reg_sel;
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pready_reg && pwrite && !pslverr_reg;
	assign busy = req_reg || state_reg != S_IDLE;
	assign data_reg_sel = paddr == OFS_CMD || paddr == OFS_WLO || paddr == OFS_WHI;

	always_comb begin
		map_hit = 1'b1;
		rd_mux = 32'h0;
		if (paddr == OFS_CFG) begin
			rd_mux = {23'h0, cfg_reg};
		end else if (paddr == OFS_TIM) begin
			rd_mux = {16'h0, tim_reg};
		end else if (paddr == OFS_LIN) begin
			rd_mux = lin_reg;
		end else if (paddr == OFS_SEG) begin
			rd_mux = {24'h0, seg_reg};
		end else if (paddr == OFS_HADDR) begin
			rd_mux = haddr_reg;
		end else if (paddr == OFS_WLO) begin
			rd_mux = wdata_reg[31:0];
		end else if (paddr == OFS_WHI) begin
			rd_mux = wdata_reg[63:32];
		end else if (paddr == OFS_CMD) begin
			rd_mux = {16'h0, be_reg, 7'h0, wr_op_reg};
		end else if (paddr == OFS_RLO) begin
			rd_mux = rdata_reg[31:0];
		end else if (paddr == OFS_RHI) begin
			rd_mux = rdata_reg[63:32];
		end else if (paddr == OFS_STAT) begin
			rd_mux = 32'({cap_l2, 4'h0, open_reg, miss_reg, done_reg, busy});
		end else begin
			map_hit = 1'b0;
		end
	end

	// apb answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				pslverr_reg <= !map_hit || (pwrite && busy && data_reg_sel);
				prdata_reg <= pwrite ? 32'h0 : rd_mux;
			end
		end
	end

	// software registers; hardware set of a flag wins over its clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= fbdi_cfg_t'(CFG_RST);
			tim_reg <= fbdi_tim_t'(TIM_RST);
			lin_reg <= LIN_RST;
			seg_reg <= SEG_RST;
			haddr_reg <= 32'h0;
			wdata_reg <= 64'h0;
			be_reg <= 8'h00;
			wr_op_reg <= 1'b0;
			req_reg <= 1'b0;
			done_reg <= 1'b0;
			miss_reg <= 1'b0;
		end else begin
			if (acc_wr && paddr == OFS_CFG) cfg_reg <= fbdi_cfg_t'(pwdata[8:0]);
			if (acc_wr && paddr == OFS_TIM) tim_reg <= fbdi_tim_t'(pwdata[15:0]);
			if (acc_wr && paddr == OFS_LIN) lin_reg <= pwdata;
			if (acc_wr && paddr == OFS_SEG) seg_reg <= pwdata[7:0];
			if (acc_wr && paddr == OFS_HADDR && !busy) haddr_reg <= pwdata;
			if (acc_wr && paddr == OFS_WLO) wdata_reg[31:0] <= pwdata;
			if (acc_wr && paddr == OFS_WHI) wdata_reg[63:32] <= pwdata;
			if (acc_wr && paddr == OFS_CMD) begin
				wr_op_reg <= pwdata[CMD_WR_BIT];
				be_reg <= pwdata[CMD_BE_LSB +: 8];
			end
			req_reg <= (acc_wr && paddr == OFS_CMD) || (req_reg && !take);
			done_reg <= fin || (done_reg && !(acc_wr && paddr == OFS_STAT && pwdata[ST_DONE]));
			miss_reg <= (take && !win_hit) ||
				(miss_reg && !(acc_wr && paddr == OFS_STAT && pwdata[ST_MISS]));
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign dram = pins_reg;
	assign dq_out = wdata_reg;

	// helper counters for strobe timing checks, in pclk cycles
	logic ras_any, cas_any;
	logic [15:0] ras_hi_cnt, rcd_cnt, cas_lo_cnt;
	assign ras_any = pins_reg.ras_n != 2'h3;
	assign cas_any = pins_reg.byte_column_strobe_lines != 8'hff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ras_hi_cnt <= 16'h0;
			rcd_cnt <= 16'h0;
			cas_lo_cnt <= 16'h0;
		end else begin
			ras_hi_cnt <= ras_any ? 16'h0 : ras_hi_cnt + 16'h1;
			rcd_cnt <= (ras_any && !cas_any && state_reg == S_RCD) ? rcd_cnt + 16'h1 : 16'h0;
			cas_lo_cnt <= cas_any ? cas_lo_cnt + 16'h1 : 16'h0;
		end
	end

	AST_CAS_NEEDS_RAS: assert property (@(posedge pclk) disable iff (!presetn)
		cas_any |-> ras_any) else $error("column strobe without row strobe");
	AST_PRECHARGE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ras_any) |-> ras_hi_cnt >= 16'((tim_reg.rp + 1) * MCLK_DIV))
		else $error("precharge too short");
	AST_RAS_TO_CAS: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(cas_any) && $past(state_reg) == S_RCD) |->
		$past(rcd_cnt) + 16'h1 >= 16'((tim_reg.rcd + 1) * MCLK_DIV))
		else $error("row to column delay too short");
	AST_CAS_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(cas_any) |-> $past(cas_lo_cnt) + 16'h1 >= 16'((tim_reg.cas + 1) * MCLK_DIV))
		else $error("column strobe too short");
	AST_MCLK_RATE: assert property (@(posedge pclk) disable iff (!presetn)
		mclk_en |=> !mclk_en [*3] ##1 mclk_en) else $error("memory clock enable off rate");
	AST_PAGE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == S_IDLE && state_next == S_CAS) |=> ras_any [*4])
		else $error("row strobe dropped on page hit");
	AST_SINGLE_CAS: assert property (@(posedge pclk) disable iff (!presetn)
		(cas_any && !per_cas) |-> pins_reg.byte_column_strobe_lines == ~lanes)
		else $error("single column strobe lines split");
	AST_BYTE_WE: assert property (@(posedge pclk) disable iff (!presetn)
		(cas_any && wr_op_reg && !per_cas) |-> pins_reg.byte_write_strobe_lines == ~be_eff)
		else $error("write strobe lanes do not match byte enables");
	AST_BUS32_LANES: assert property (@(posedge pclk) disable iff (!presetn)
		(!cfg_reg.bus64 && $stable(cfg_reg)) |-> pins_reg.byte_write_strobe_lines[7:4] == 4'hf)
		else $error("upper lanes strobed on 32-bit bus");
	AST_MISS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		(take && !win_hit) |=> miss_reg && state_reg == S_IDLE) else $error("window miss lost");
	AST_CAP_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
		cap_l2 <= 5'h17 && cap_l2 >= 5'h11) else $error("capacity out of range");
endmodule

// File: rtl/fbdi_phase_cnt.sv
// fbdi_phase_cnt: loadable down counter timing one strobe phase in memory clock ticks
module fbdi_phase_cnt import fbdi_pkg::*; #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic load,
	input wire logic [W-1:0] val,
	input wire logic dec,
	// status
	output logic zero
);
	logic [W-1:0] cnt_reg;

	// load wins; otherwise count down and hold at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= val;
		end else if (dec && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign zero = (cnt_reg == '0);
endmodule

// File: rtl/fbdi_pkg.sv
// fbdi_pkg: constants, types and geometry table of the frame buffer dram interface
package fbdi_pkg;
	// clocking: the memory cycle rate is an enable pulse derived from pclk
	localparam int PCLK_MHZ = 200;
	localparam int MCLK_MAX_MHZ = 66;
	localparam int MCLK_DIV = (PCLK_MHZ + MCLK_MAX_MHZ - 1) / MCLK_MAX_MHZ;
	localparam int IDLE_CLOSE_MCLK = 16;

	// register offsets (byte addresses)
	localparam logic [11:0] OFS_CFG = 12'h000;
	localparam logic [11:0] OFS_TIM = 12'h004;
	localparam logic [11:0] OFS_LIN = 12'h008;
	localparam logic [11:0] OFS_SEG = 12'h00c;
	localparam logic [11:0] OFS_HADDR = 12'h010;
	localparam logic [11:0] OFS_WLO = 12'h014;
	localparam logic [11:0] OFS_WHI = 12'h018;
	localparam logic [11:0] OFS_CMD = 12'h01c;
	localparam logic [11:0] OFS_RLO = 12'h020;
	localparam logic [11:0] OFS_RHI = 12'h024;
	localparam logic [11:0] OFS_STAT = 12'h028;

	// reset values
	localparam logic [8:0] CFG_RST = 9'h08b;
	localparam logic [15:0] TIM_RST = 16'hffff;
	localparam logic [31:0] LIN_RST = 32'h00000000;
	localparam logic [7:0] SEG_RST = 8'h00;

	// host windows
	localparam logic [31:0] LEG_LO = 32'h000a0000;
	localparam logic [31:0] LEG_HI = 32'h000bffff;
	localparam logic [31:0] LIN_MIN = 32'h00100000;
	localparam logic [31:0] ISA_TOP = 32'h01000000;

	// command and status fields
	localparam int CMD_WR_BIT = 0;
	localparam int CMD_BE_LSB = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_MISS = 2;
	localparam int ST_ROW = 3;
	localparam int ST_CAP_LSB = 8;
	localparam logic [7:0] LANES_64 = 8'hff;
	localparam logic [7:0] LANES_32 = 8'h0f;

	typedef enum logic [2:0] {
		T64K16 = 3'h0,
		T256K4 = 3'h1,
		T256K8 = 3'h2,
		T256K16_9 = 3'h3,
		T256K16_10 = 3'h4,
		T512K8 = 3'h5,
		T1M4 = 3'h6
	} fbdi_dram_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_PRE = 3'h1,
		S_RCD = 3'h2,
		S_CAS = 3'h3,
		S_CLOSE = 3'h4
	} fbdi_state_t;

	typedef struct packed {
		logic isa;
		logic leg_en;
		logic lin_en;
		logic swap;
		logic two_banks;
		logic bus64;
		logic [2:0] dtype;
	} fbdi_cfg_t;

	typedef struct packed {
		logic [3:0] rcd;
		logic [3:0] cas;
		logic [3:0] ras;
		logic [3:0] rp;
	} fbdi_tim_t;

	typedef struct packed {
		logic [9:0] addr;
		logic [1:0] ras_n;
		logic [7:0] byte_column_strobe_lines;
		logic [7:0] byte_write_strobe_lines;
		logic dq_oe;
	} fbdi_pins_t;

	localparam fbdi_pins_t PINS_IDLE = '{10'h000, 2'h3, 8'hff, 8'hff, 1'b0};

	typedef struct packed {
		logic [4:0] row;
		logic [4:0] col;
		logic [4:0] bank_l2;
		logic [4:0] max_l2;
		logic [4:0] min_l2;
		logic two_ras;
		logic wide_cas;
	} fbdi_geom_t;

	// address split and size limits of each part organisation
	function automatic fbdi_geom_t fbdi_geom(logic [2:0] t);
		case (t)
			T64K16: return '{5'h08, 5'h08, 5'h12, 5'h15, 5'h12, 1'b1, 1'b0};
			T256K4: return '{5'h09, 5'h09, 5'h15, 5'h15, 5'h14, 1'b0, 1'b0};
			T256K8: return '{5'h09, 5'h09, 5'h15, 5'h16, 5'h14, 1'b1, 1'b1};
			T256K16_10: return '{5'h0a, 5'h08, 5'h15, 5'h15, 5'h14, 1'b0, 1'b0};
			T512K8: return '{5'h0a, 5'h09, 5'h16, 5'h16, 5'h15, 1'b1, 1'b0};
			T1M4: return '{5'h0a, 5'h0a, 5'h17, 5'h17, 5'h16, 1'b0, 1'b0};
			default: return '{5'h09, 5'h09, 5'h15, 5'h16, 5'h14, 1'b1, 1'b0};
		endcase
	endfunction

	// installed size as log2 bytes, clamped to the part's limits
	function automatic logic [4:0] fbdi_cap_l2(fbdi_geom_t g, logic bus64, logic two_banks);
		logic [4:0] l;
		l = g.bank_l2 + 5'(g.two_ras & two_banks) - 5'(!bus64);
		if (l > g.max_l2) begin
			l = g.max_l2;
		end else if (l < g.min_l2) begin
			l = g.min_l2;
		end
		return l;
	endfunction
endpackage

// File: tb/fbdi_ctrl_bench.sv
// fbdi_ctrl_bench: apb-driven bench for the frame buffer dram controller
module fbdi_ctrl_bench import fbdi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	fbdi_pins_t dram;
	logic [63:0] dq_out, dq_in;
	logic [15:0] strobes;
	int ras_falls, rcd_cyc, cas_cyc, n0;
	int fails = 0;
	int total_checks = 0;
	logic [4:0] cap_hi [7] = '{5'h13, 5'h15, 5'h16, 5'h16, 5'h15, 5'h16, 5'h17};
	logic [4:0] cap_lo [7] = '{5'h12, 5'h14, 5'h14, 5'h14, 5'h14, 5'h15, 5'h16};

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	fbdi_ctrl #(.IDLE_CLOSE(40)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dram(dram),
		.dq_out(dq_out), .dq_in(dq_in));
	fbdi_dram_model mem_model (.pclk(pclk), .dram(dram), .dq_out(dq_out), .dq_in(dq_in),
		.ras_falls(ras_falls), .rcd_cyc(rcd_cyc), .cas_cyc(cas_cyc), .strobes(strobes));

	// verdict and end of run
	task automatic give_verdict();
		if (fails == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, then access until pready, then an idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			give_verdict();
		end
		rq = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] rq;
		logic e;
		apb(1'b1, a, d, rq, e);
		check(e, exp_err);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check({e, q & m}, {1'b0, exp & m});
	endtask

	// start one memory access and wait for done or window miss, then clear both
	task automatic access(input logic [31:0] ha, input logic w, input logic [7:0] be);
		logic e;
		int n;
		wr(OFS_HADDR, ha, 1'b0);
		wr(OFS_CMD, {16'h0000, be, 7'h00, w}, 1'b0);
		n = 0;
		do begin
			apb(1'b0, OFS_STAT, 32'h0, q, e);
			n++;
		end while (q[ST_DONE] !== 1'b1 && q[ST_MISS] !== 1'b1 && n < 300);
		if (n >= 300) begin
			fails++;
			give_verdict();
		end
		wr(OFS_STAT, 32'h00000006, 1'b0);
	endtask

	task automatic wr_mem(input logic [31:0] ha, input logic [63:0] d, input logic [7:0] be);
		wr(OFS_WLO, d[31:0], 1'b0);
		wr(OFS_WHI, d[63:32], 1'b0);
		access(ha, 1'b1, be);
	endtask

	task automatic rd_mem(input logic [31:0] ha, input logic [63:0] exp, input logic [63:0] m);
		access(ha, 1'b0, 8'hff);
		rd(OFS_RLO, exp[31:0], m[31:0]);
		rd(OFS_RHI, exp[63:32], m[63:32]);
	endtask

	// main sequence
	initial begin
		logic e;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CFG, 32'h0000008b, '1);
		rd(OFS_TIM, 32'h0000ffff, '1);
		rd(OFS_STAT, 32'h00001500, '1);
		foreach (cap_hi[i]) begin
			apb(1'b0, 12'h02c + 12'(4 * i), 32'h0, q, e);
			check(e, 1'b1);
		end
		apb(1'b0, 12'h006, 32'h0, q, e);
		check(e, 1'b1);
		// shortest and stretched strobe phases
		wr(OFS_TIM, 32'h00000000, 1'b0);
		wr_mem(LEG_LO, 64'h0123456789abcdef, 8'hff);
		check(rcd_cyc, 4);
		check(cas_cyc, 4);
		wr_mem(LEG_LO, 64'hfedcba9876543210, 8'h0f);
		check(strobes, 16'h00f0);
		rd_mem(LEG_LO, 64'h0123456776543210, '1);
		wr(OFS_CFG, 32'h000000ab, 1'b0);
		wr_mem(LEG_LO, 64'h55aa55aa11111111, 8'hf0);
		check(strobes, 16'h0f00);
		rd_mem(LEG_LO, 64'h55aa55aa76543210, '1);
		wr(OFS_TIM, 32'h00003200, 1'b0);
		n0 = ras_falls;
		wr_mem(LEG_LO + 32'h1000, 64'h0badf00d12345678, 8'hff);
		check(rcd_cyc, 16);
		check(cas_cyc, 12);
		wr_mem(LEG_LO + 32'h1008, 64'h00000000cafebabe, 8'hff);
		rd_mem(LEG_LO + 32'h1000, 64'h0badf00d12345678, '1);
		check(ras_falls, n0 + 1);
		repeat (200) @(posedge pclk);
		check(dram.ras_n, 2'h3);
		rd(OFS_STAT, 32'h0, 32'h00000008);
		// host windows: misses, linear view, segment view, isa limit
		access(32'h00050000, 1'b0, 8'hff);
		check(q[ST_MISS:ST_DONE], 2'b10);
		wr(OFS_CFG, 32'h000000cb, 1'b0);
		wr(OFS_LIN, 32'h00200000, 1'b0);
		rd_mem(32'h00201000, 64'h0badf00d12345678, '1);
		wr(OFS_SEG, 32'h00000001, 1'b0);
		wr_mem(LEG_LO, 64'h1357924680aceb0d, 8'hff);
		rd_mem(32'h00210000, 64'h1357924680aceb0d, '1);
		wr(OFS_LIN, 32'h000c0000, 1'b0);
		access(32'h000c0000, 1'b0, 8'hff);
		check(q[ST_MISS:ST_DONE], 2'b10);
		wr(OFS_CFG, 32'h000001cb, 1'b0);
		wr(OFS_LIN, 32'h01000000, 1'b0);
		access(32'h01000000, 1'b0, 8'hff);
		check(q[ST_MISS:ST_DONE], 2'b10);
		// every part type on a 64-bit two-bank bus and a 32-bit one-bank bus
		wr(OFS_TIM, 32'h00000000, 1'b0);
		for (int i = 0; i < 14; i++) begin
			wr(OFS_CFG, 32'h80 | 32'(i / 2) | ((i % 2) ? 32'h0 : 32'h18), 1'b0);
			rd(OFS_STAT, {19'h0, (i % 2) ? cap_lo[i / 2] : cap_hi[i / 2], 8'h00}, 32'h1f00);
			wr_mem(LEG_LO + 32'h18, {32'(i) * 32'h01010101, 32'h5a5a0000 + 32'(i)}, 8'hff);
			rd_mem(LEG_LO + 32'h18, {32'(i) * 32'h01010101, 32'h5a5a0000 + 32'(i)},
				(i % 2) ? 64'h00000000ffffffff : '1);
		end
		give_verdict();
	end
endmodule

// File: tb/fbdi_dram_model.sv
// fbdi_dram_model: behavioural fast page mode dram pair with strobe timing probes
module fbdi_dram_model import fbdi_pkg::*; (
	// clock
	input wire logic pclk,
	// dram pins
	input wire fbdi_pins_t dram,
	input wire logic [63:0] dq_out,
	output logic [63:0] dq_in,
	// probes for the bench
	output int ras_falls,
	output int rcd_cyc,
	output int cas_cyc,
	output logic [15:0] strobes
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] mem [int];
	logic [63:0] w;
	logic [9:0] row;
	logic bank;
	logic [1:0] ras_q;
	logic [7:0] col_q;
	logic [7:0] lanes;
	int key, t, t0, tc;

	initial begin
		{dq_in, ras_falls, rcd_cyc, cas_cyc, strobes} = '0;
		{row, bank, key, t, t0, tc} = '0;
		ras_q = 2'h3;
		col_q = 8'hff;
	end

	// a lane is written only where its column and write lines are both low
	assign lanes = ~(dram.byte_column_strobe_lines | dram.byte_write_strobe_lines);

	// row latch on row strobe fall, column latch on column strobe fall
	always @(posedge pclk) begin
		if (ras_q == 2'h3 && dram.ras_n != 2'h3) begin
			row = dram.addr;
			bank = ~dram.ras_n[1];
			ras_falls++;
			t0 = t;
		end
		if (col_q == 8'hff && dram.byte_column_strobe_lines != 8'hff) begin
			key = {bank, row, dram.addr};
			rcd_cyc = t - t0;
			tc = t;
			strobes = {dram.byte_column_strobe_lines, dram.byte_write_strobe_lines};
		end
		if (col_q != 8'hff && dram.byte_column_strobe_lines == 8'hff) begin
			cas_cyc = t - tc;
		end
		// data lines carry the cell only in a read column phase, else a toggling pattern
		if (dram.byte_column_strobe_lines != 8'hff) begin
			w = mem.exists(key) ? mem[key] : 64'h0;
			if (dram.dq_oe) begin
				for (int i = 0; i < 8; i++) begin
					if (lanes[i]) begin
						w[8*i+:8] = dq_out[8*i+:8];
					end
				end
				mem[key] = w;
				dq_in <= ~dq_in;
			end else begin
				dq_in <= w;
			end
		end else begin
			dq_in <= ~dq_in;
		end
		ras_q = dram.ras_n;
		col_q = dram.byte_column_strobe_lines;
		t++;
	end
endmodule
